/* File: rtl/exec_slice.sv */
// Execute slice: seven core operations
`timescale 1ns/10ps
`default_nettype none
module exec_slice (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Decoded instruction
  input wire logic op_valid,
  input wire exec_slice_pkg::op_t op,
  input wire logic [exec_slice_pkg::FADDR_W-1:0] file_addr,
  input wire logic dest_sel,
  // Core state
  input wire logic [exec_slice_pkg::DATA_W-1:0] file_rdata,
  input wire logic [exec_slice_pkg::DATA_W-1:0] acc_in,
  input wire logic [exec_slice_pkg::PC_W-1:0] pc_in,
  input wire logic [exec_slice_pkg::PC_HI_W-1:0] pc_high_latch,
  // File register write
  output logic file_we,
  output logic [exec_slice_pkg::FADDR_W-1:0] file_waddr,
  output logic [exec_slice_pkg::DATA_W-1:0] file_wdata,
  // Accumulator write
  output logic acc_we,
  output logic [exec_slice_pkg::DATA_W-1:0] acc_wdata,
  // Program counter and return stack
  output logic pc_load,
  output logic [exec_slice_pkg::PC_W-1:0] pc_wdata,
  output logic stack_push,
  output logic [exec_slice_pkg::PC_W-1:0] return_stack_top,
  // Status flags
  output logic zero_flag_we,
  output logic zero_flag_value,
  output logic timeout_status_flag_set,
  output logic power_down_status_flag_set,
  // Watchdog
  output logic watchdog_counter_clear,
  output logic watchdog_prescaler_clear,
  // Pipeline control
  output logic busy,
  output logic flush_next
);
  import exec_slice_pkg::*;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  state_t state_q;
  state_t state_d;
  wire logic [DATA_W-1:0] alu_result;
  wire logic alu_zero;
  wire logic run;
  wire logic is_wd_clear;
  wire logic is_call;
  wire logic is_compl;
  wire logic is_clear_file;
  wire logic is_clear_acc;
  wire logic is_dec;
  wire logic is_dec_skip;
  wire logic uses_dest;
  wire logic to_file;
  wire logic to_acc;
  wire logic skip;
  wire logic two_cycle;
  wire logic zero_write;
  wire logic zero_forced;

  file_alu u_alu (
    .op(op),
    .file_data(file_rdata),
    .result(alu_result),
    .result_zero(alu_zero)
  );

  assign run = op_valid && (state_q == ST_EXEC);
  assign is_wd_clear = run && (op == OP_WATCHDOG_CLEAR);
  assign is_call = run && (op == OP_CALL_ACC);
  assign is_compl = run && (op == OP_COMPLEMENT);
  assign is_clear_file = run && (op == OP_CLEAR_FILE);
  assign is_clear_acc = run && (op == OP_CLEAR_ACC);
  assign is_dec = run && (op == OP_DECREMENT);
  assign is_dec_skip = run && (op == OP_DEC_SKIP);
  assign uses_dest = is_compl || is_dec || is_dec_skip;
  assign to_file = uses_dest && (dest_sel == DEST_FILE); // RULE8
  assign to_acc = uses_dest && (dest_sel == DEST_ACC); // RULE8
  assign skip = is_dec_skip && alu_zero; // RULE13 RULE14
  assign two_cycle = is_call || skip; // RULE6 RULE16
  assign zero_write = is_compl || is_dec || is_clear_file || is_clear_acc; // RULE15 RULE14
  assign zero_forced = is_clear_file || is_clear_acc; // RULE9 RULE10

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  wire logic file_we_d;
  wire logic [FADDR_W-1:0] file_waddr_d;
  wire logic [DATA_W-1:0] file_wdata_d;
  wire logic acc_we_d;
  wire logic [DATA_W-1:0] acc_wdata_d;
  wire logic pc_load_d;
  wire logic [PC_W-1:0] pc_wdata_d;
  wire logic stack_push_d;
  wire logic [PC_W-1:0] return_stack_top_d;
  wire logic zero_flag_we_d;
  wire logic zero_flag_value_d;
  wire logic timeout_set_d;
  wire logic power_down_set_d;
  wire logic watchdog_counter_clear_d;
  wire logic watchdog_prescaler_clear_d;

  assign file_we_d = to_file || is_clear_file; // RULE8 RULE9
  assign file_waddr_d = file_addr; // RULE17
  assign file_wdata_d = is_clear_file ? DATA_ZERO : alu_result; // RULE7 RULE9 RULE11 RULE12
  assign acc_we_d = to_acc || is_clear_acc; // RULE8 RULE10
  assign acc_wdata_d = is_clear_acc ? DATA_ZERO : alu_result; // RULE10
  assign pc_load_d = is_call; // RULE5
  assign pc_wdata_d = {pc_high_latch, acc_in}; // RULE5
  assign stack_push_d = is_call; // RULE4
  assign return_stack_top_d = PC_W'(pc_in + PC_ONE); // RULE4
  assign zero_flag_we_d = zero_write; // RULE15 RULE9 RULE10
  assign zero_flag_value_d = zero_forced ? 1'b1 : alu_zero; // RULE15
  assign timeout_set_d = is_wd_clear; // RULE3
  assign power_down_set_d = is_wd_clear; // RULE3
  assign watchdog_counter_clear_d = is_wd_clear; // RULE1
  assign watchdog_prescaler_clear_d = is_wd_clear; // RULE2

  // ----------------------------------------
  // Two-cycle sequencing
  // ----------------------------------------
  always_comb begin
    case (state_q)
      ST_EXEC: state_d = two_cycle ? ST_SECOND : ST_EXEC; // RULE6 RULE16
      ST_SECOND: state_d = ST_EXEC;
      default: state_d = ST_EXEC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // File register write
  // ----------------------------------------
  logic file_we_q;
  logic [FADDR_W-1:0] file_waddr_q;
  logic [DATA_W-1:0] file_wdata_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      file_we_q <= 1'b0;
      file_waddr_q <= '0;
      file_wdata_q <= DATA_ZERO;
    end else begin
      file_we_q <= file_we_d;
      file_waddr_q <= file_waddr_d;
      file_wdata_q <= file_wdata_d;
    end
  end

  // ----------------------------------------
  // Accumulator write
  // ----------------------------------------
  logic acc_we_q;
  logic [DATA_W-1:0] acc_wdata_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc_we_q <= 1'b0;
      acc_wdata_q <= DATA_ZERO;
    end else begin
      acc_we_q <= acc_we_d;
      acc_wdata_q <= acc_wdata_d;
    end
  end

  // ----------------------------------------
  // Program counter and return stack
  // ----------------------------------------
  logic pc_load_q;
  logic [PC_W-1:0] pc_wdata_q;
  logic stack_push_q;
  logic [PC_W-1:0] return_stack_top_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pc_load_q <= 1'b0;
      pc_wdata_q <= PC_RESET;
      stack_push_q <= 1'b0;
      return_stack_top_q <= PC_RESET;
    end else begin
      pc_load_q <= pc_load_d;
      pc_wdata_q <= pc_wdata_d;
      stack_push_q <= stack_push_d;
      return_stack_top_q <= return_stack_top_d;
    end
  end

  // ----------------------------------------
  // Status flags and watchdog
  // ----------------------------------------
  logic zero_flag_we_q;
  logic zero_flag_value_q;
  logic timeout_set_q;
  logic power_down_set_q;
  logic watchdog_counter_clear_q;
  logic watchdog_prescaler_clear_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      zero_flag_we_q <= 1'b0;
      zero_flag_value_q <= 1'b0;
    end else begin
      zero_flag_we_q <= zero_flag_we_d;
      zero_flag_value_q <= zero_flag_value_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timeout_set_q <= 1'b0;
      power_down_set_q <= 1'b0;
      watchdog_counter_clear_q <= 1'b0;
      watchdog_prescaler_clear_q <= 1'b0;
    end else begin
      timeout_set_q <= timeout_set_d;
      power_down_set_q <= power_down_set_d;
      watchdog_counter_clear_q <= watchdog_counter_clear_d;
      watchdog_prescaler_clear_q <= watchdog_prescaler_clear_d;
    end
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  assign file_we = file_we_q;
  assign file_waddr = file_waddr_q;
  assign file_wdata = file_wdata_q;
  assign acc_we = acc_we_q;
  assign acc_wdata = acc_wdata_q;
  assign pc_load = pc_load_q;
  assign pc_wdata = pc_wdata_q;
  assign stack_push = stack_push_q;
  assign return_stack_top = return_stack_top_q;
  assign zero_flag_we = zero_flag_we_q;
  assign zero_flag_value = zero_flag_value_q;
  assign timeout_status_flag_set = timeout_set_q;
  assign power_down_status_flag_set = power_down_set_q;
  assign watchdog_counter_clear = watchdog_counter_clear_q;
  assign watchdog_prescaler_clear = watchdog_prescaler_clear_q;

  // ----------------------------------------
  // Pipeline control
  // ----------------------------------------
  assign busy = (state_q == ST_SECOND);
  assign flush_next = two_cycle; // RULE14 RULE6
endmodule // exec_slice
`default_nettype wire

/* File: rtl/exec_slice_pkg.sv */
// Constants and types for the instruction execute slice
// Functional notes
// RULE1 - Watchdog clear loads watchdog counter zero
// RULE2 - Watchdog clear also zeroes the prescaler
// RULE3 - Watchdog clear sets timeout and power-down flags
// RULE4 - Indirect call pushes PC plus one
// RULE5 - PC low from accumulator, high from latch
// RULE6 - Indirect call takes two cycles, flags kept
// RULE7 - Complement result is inverse of file
// RULE8 - Destination bit: 0 accumulator, 1 file
// RULE9 - Clear file writes zero, sets zero flag
// RULE10 - Clear accumulator writes zero, sets zero flag
// RULE11 - Decrement file subtracts one to destination
// RULE12 - Decrement-skip subtracts one to destination
// RULE13 - Nonzero decrement-skip result runs next instruction
// RULE14 - Zero result discards next, flags untouched
// RULE15 - Complement and decrement update zero flag
// RULE16 - Skip takes two cycles, else one
// RULE17 - Seven-bit file address, one-bit destination
package exec_slice_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 15;
  localparam int PC_LO_W = 8;
  localparam int PC_HI_W = 7;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_WATCHDOG_CLEAR = 4'h1,
    OP_CALL_ACC = 4'h2,
    OP_COMPLEMENT = 4'h3,
    OP_CLEAR_FILE = 4'h4,
    OP_CLEAR_ACC = 4'h5,
    OP_DECREMENT = 4'h6,
    OP_DEC_SKIP = 4'h7
  } op_t;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_SECOND = 2'b10
  } state_t;
endpackage

/* File: rtl/file_alu.sv */
// Result and zero detect for file operations
`timescale 1ns/10ps
`default_nettype none
module file_alu (
  // Operation and operand
  input wire exec_slice_pkg::op_t op,
  input wire logic [exec_slice_pkg::DATA_W-1:0] file_data,
  // Result
  output logic [exec_slice_pkg::DATA_W-1:0] result,
  output logic result_zero
);
  import exec_slice_pkg::*;
  wire logic [DATA_W-1:0] inv_value;
  wire logic [DATA_W-1:0] dec_value;
  assign inv_value = ~file_data; // RULE7
  assign dec_value = file_data - DATA_ONE; // RULE11 RULE12
  assign result = (op == OP_COMPLEMENT) ? inv_value :
                  (op == OP_DECREMENT || op == OP_DEC_SKIP) ? dec_value : DATA_ZERO;
  assign result_zero = (result == DATA_ZERO);
endmodule // file_alu
`default_nettype wire

/* File: sim/exec_slice_properties.sv */
// Checker for the execute slice
`timescale 1ns/10ps
`default_nettype none
module exec_slice_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Decoded instruction
  input wire logic op_valid,
  input wire exec_slice_pkg::op_t op,
  input wire logic dest_sel,
  // Core state
  input wire logic [exec_slice_pkg::DATA_W-1:0] file_rdata,
  input wire logic [exec_slice_pkg::DATA_W-1:0] acc_in,
  input wire logic [exec_slice_pkg::PC_W-1:0] pc_in,
  input wire logic [exec_slice_pkg::PC_HI_W-1:0] pc_high_latch,
  // Register writes
  input wire logic file_we,
  input wire logic [exec_slice_pkg::DATA_W-1:0] file_wdata,
  input wire logic acc_we,
  input wire logic [exec_slice_pkg::DATA_W-1:0] acc_wdata,
  // Program counter and return stack
  input wire logic pc_load,
  input wire logic [exec_slice_pkg::PC_W-1:0] pc_wdata,
  input wire logic stack_push,
  input wire logic [exec_slice_pkg::PC_W-1:0] return_stack_top,
  // Status flags and watchdog
  input wire logic zero_flag_we,
  input wire logic zero_flag_value,
  input wire logic timeout_status_flag_set,
  input wire logic power_down_status_flag_set,
  input wire logic watchdog_counter_clear,
  input wire logic watchdog_prescaler_clear,
  // Pipeline control
  input wire logic busy,
  input wire logic flush_next
);
  import exec_slice_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic go = op_valid && !busy;
  wire logic call = go && op == OP_CALL_ACC;
  watchdog_clear_a: assert property (go && op == OP_WATCHDOG_CLEAR |=>
    watchdog_counter_clear && watchdog_prescaler_clear && timeout_status_flag_set &&
    power_down_status_flag_set && !zero_flag_we) else $error("watchdog clear");
  call_push_a: assert property (call |=> stack_push &&
    return_stack_top == $past(pc_in) + PC_ONE) else $error("push");
  call_pc_a: assert property (call |=> pc_load &&
    pc_wdata == {$past(pc_high_latch), $past(acc_in)}) else $error("pc load");
  call_busy_a: assert property (call |->
    flush_next ##1 busy && !zero_flag_we) else $error("call timing");
  dest_file_a: assert property (go && dest_sel && op == OP_DECREMENT |=>
    file_we && !acc_we) else $error("dest");
  clear_file_a: assert property (go && op == OP_CLEAR_FILE |=> file_we &&
    file_wdata == DATA_ZERO && zero_flag_value) else $error("clear file");
  clear_acc_a: assert property (go && op == OP_CLEAR_ACC |=> acc_we &&
    acc_wdata == DATA_ZERO && zero_flag_value) else $error("clear acc");
  skip_zero_a: assert property (go && op == OP_DEC_SKIP && file_rdata == DATA_ONE |->
    flush_next ##1 busy && !zero_flag_we) else $error("skip");
  skip_nonzero_a: assert property (go && op == OP_DEC_SKIP && file_rdata != DATA_ONE |->
    !flush_next ##1 !busy && !zero_flag_we) else $error("no skip");
  compl_zero_a: assert property (go && op == OP_COMPLEMENT |=> zero_flag_we &&
    zero_flag_value == (~$past(file_rdata) == DATA_ZERO)) else $error("complement zero");
  cover property (call);
  cover property (go && op == OP_WATCHDOG_CLEAR);
  cover property (go && dest_sel && op == OP_DECREMENT);
  cover property (go && op == OP_DEC_SKIP && file_rdata == DATA_ONE);
endmodule // exec_slice_props
bind exec_slice exec_slice_props u_props (
  .clk(clk),
  .reset_n(reset_n),
  .op_valid(op_valid),
  .op(op),
  .dest_sel(dest_sel),
  .file_rdata(file_rdata),
  .acc_in(acc_in),
  .pc_in(pc_in),
  .pc_high_latch(pc_high_latch),
  .file_we(file_we),
  .file_wdata(file_wdata),
  .acc_we(acc_we),
  .acc_wdata(acc_wdata),
  .pc_load(pc_load),
  .pc_wdata(pc_wdata),
  .stack_push(stack_push),
  .return_stack_top(return_stack_top),
  .zero_flag_we(zero_flag_we),
  .zero_flag_value(zero_flag_value),
  .timeout_status_flag_set(timeout_status_flag_set),
  .power_down_status_flag_set(power_down_status_flag_set),
  .watchdog_counter_clear(watchdog_counter_clear),
  .watchdog_prescaler_clear(watchdog_prescaler_clear),
  .busy(busy),
  .flush_next(flush_next)
);
`default_nettype wire

/* File: sim/exec_slice_tb.sv */
// Bench for the execute slice
`timescale 1ns/10ps
`default_nettype none
module exec_slice_tb;
  import exec_slice_pkg::*;
  logic clk = 0, reset_n = 0, op_valid = 0, dest_sel, busy, flush_next, file_we, acc_we;
  op_t op = OP_NONE;
  logic [6:0] file_addr, pc_high_latch, file_waddr;
  logic [7:0] file_rdata, acc_in, file_wdata, acc_wdata, r;
  logic [14:0] pc_in, pc_wdata, return_stack_top;
  logic pc_load, stack_push, zero_flag_we, zero_flag_value, watchdog_counter_clear;
  logic watchdog_prescaler_clear, timeout_status_flag_set, power_down_status_flag_set;
  logic fo, ao, two, zw;
  logic [7:0] model_r;
  logic [7:0] model_queue[$];
  int n_fail = 0, total_checks = 0, seed = 32'h1F7D695D;
  exec_slice dut (
    .clk(clk),
    .reset_n(reset_n),
    .op_valid(op_valid),
    .op(op),
    .file_addr(file_addr),
    .dest_sel(dest_sel),
    .file_rdata(file_rdata),
    .acc_in(acc_in),
    .pc_in(pc_in),
    .pc_high_latch(pc_high_latch),
    .file_we(file_we),
    .file_waddr(file_waddr),
    .file_wdata(file_wdata),
    .acc_we(acc_we),
    .acc_wdata(acc_wdata),
    .pc_load(pc_load),
    .pc_wdata(pc_wdata),
    .stack_push(stack_push),
    .return_stack_top(return_stack_top),
    .zero_flag_we(zero_flag_we),
    .zero_flag_value(zero_flag_value),
    .timeout_status_flag_set(timeout_status_flag_set),
    .power_down_status_flag_set(power_down_status_flag_set),
    .watchdog_counter_clear(watchdog_counter_clear),
    .watchdog_prescaler_clear(watchdog_prescaler_clear),
    .busy(busy),
    .flush_next(flush_next)
  );
  initial forever #2 clk = ~clk;
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t: %s", $time, m);
    end
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task do_op(input op_t o, input logic [7:0] f);
    @(posedge clk);
    #1 {dest_sel, file_addr, acc_in, pc_in, pc_high_latch} = 38'({$random(seed), $random(seed)});
    op_valid = 1'b1;
    op = o;
    file_rdata = f;
    zw = o inside {OP_COMPLEMENT, OP_DECREMENT, OP_DEC_SKIP};
    r = o == OP_COMPLEMENT ? ~f : zw ? f - 8'h01 : 8'h00;
    fo = o == OP_CLEAR_FILE || zw && dest_sel;
    ao = o == OP_CLEAR_ACC || zw && !dest_sel;
    two = o == OP_CALL_ACC || o == OP_DEC_SKIP && r == 8'h00;
    model_queue.push_back(r);
    zw = o inside {[OP_COMPLEMENT:OP_DECREMENT]};
    #1 chk(flush_next === two, "flush");
    @(posedge clk);
    #1 op_valid = two;
    chk({file_we, acc_we, stack_push, pc_load, busy} ===
      {fo, ao, {2{o == OP_CALL_ACC}}, two}, "strobes");
    model_r = model_queue.pop_front();
    chk({watchdog_counter_clear, watchdog_prescaler_clear, timeout_status_flag_set,
      power_down_status_flag_set} === {4{o == OP_WATCHDOG_CLEAR}}, "watchdog");
    chk(zero_flag_we === zw && (!zw || zero_flag_value === (r == 8'h00)), "zero");
    if (fo) chk(file_wdata === model_r && file_waddr === file_addr, "file");
    if (ao) chk(acc_wdata === model_r, "acc");
    if (o == OP_CALL_ACC) chk(return_stack_top === pc_in + PC_ONE &&
      pc_wdata === {pc_high_latch, acc_in}, "call");
    @(posedge clk);
    #1 op_valid = 0;
    chk({file_we, acc_we, stack_push, pc_load, busy} === 5'h00, "refused");
    $display("op %0d done", o);
  endtask
  initial begin
    {dest_sel, file_addr, acc_in, pc_in, pc_high_latch, file_rdata} = '0;
    repeat (8) @(posedge clk);
    #1 reset_n = 1;
    chk({file_we, acc_we, stack_push, pc_load, zero_flag_we, watchdog_counter_clear, busy} ===
      7'h00, "reset idle");
    for (int i = 0; i < 120; i++)
      do_op(op_t'(4'(i % 8)), i % 3 == 0 ? 8'h01 : i % 5 == 0 ? 8'hFF : 8'($random(seed)));
    @(posedge clk);
    #1 op_valid = 1'b1;
    op = OP_CALL_ACC;
    @(posedge clk);
    #1 reset_n = 1'b0;
    chk(busy === 1'b1 && stack_push === 1'b1, "call before reset");
    @(posedge clk);
    #1 reset_n = 1'b1;
    op_valid = 1'b0;
    chk({busy, stack_push, pc_load, file_we, acc_we} === 5'h00, "reset in busy");
    $display("mid-run reset done");
    end_of_test;
  end
endmodule // exec_slice_tb
`default_nettype wire
